// File: hdl/rffmt_burst_counter.sv
// Burst clock counter and timestamp/event-number keeper.
// Assumes start and end of burst arrive as one-cycle synchronous pulses.
module rffmt_burst_counter
  import rffmt_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Timing link
  input  wire logic                      burstStart,
  input  wire logic                      burstEnd,
  input  wire logic                      hwTrigPulse,
  // Results
  output logic [RFFMT_TS_W-1:0]          timestamp,
  output logic [RFFMT_TS_W-1:0]          burstCount,
  output logic [RFFMT_EVT_W-1:0]         eventNumber,
  output logic                           inBurst
);

  logic [RFFMT_TS_CNT_W-1:0] tsCnt_r;
  logic [RFFMT_TS_W-1:0]     burstCnt_r;
  logic [RFFMT_EVT_W-1:0]    evtCnt_r;
  logic                      inBurst_r;

  // Timestamp and event numbers restart at each burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsCnt_r   <= '0;
      inBurst_r <= 1'b0;
    end else if (burstStart) begin
      tsCnt_r   <= '0;
      inBurst_r <= 1'b1;
    end else begin
      tsCnt_r <= tsCnt_r + 1'b1;
      if (burstEnd) begin
        inBurst_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burstCnt_r <= '0;
    end else if (burstStart) begin
      burstCnt_r <= '0;
    end else if (inBurst_r) begin
      burstCnt_r <= burstCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evtCnt_r <= '0;
    end else if (burstStart) begin
      evtCnt_r <= '0;
    end else if (hwTrigPulse) begin
      evtCnt_r <= evtCnt_r + 1'b1;
    end
  end

  assign timestamp   = {1'b0, tsCnt_r};
  assign burstCount  = burstCnt_r;
  assign eventNumber = evtCnt_r;
  assign inBurst     = inBurst_r;

endmodule

// File: hdl/rffmt_formatter.sv
// Top of the readout frame and primitive formatter.
// Assumes timing-link pulses are one cycle and synchronous to clk; the detector
// block arrives as a valid/ready word stream whose length is given at the accept.
module rffmt_formatter
  import rffmt_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Configuration
  input  wire logic [7:0]                srcId,
  input  wire logic [RFFMT_TS_W-1:0]     tsOffset,
  input  wire logic [RFFMT_FINE_W-1:0]   fineMask,
  // Timing link
  input  wire logic                      burstStart,
  input  wire logic                      burstEnd,
  input  wire logic                      hwTrigPulse,
  input  wire logic [7:0]                hwTrigType,
  input  wire logic                      countReq,
  input  wire logic                      statusReq,
  // Second-level accept
  input  wire logic                      slAccept,
  input  wire logic [RFFMT_TTYPE_W-1:0]  slTrigType,
  input  wire logic [RFFMT_EVT_W-1:0]    slEventNum,
  input  wire logic [RFFMT_TS_W-1:0]     slTimestamp,
  input  wire logic [RFFMT_BLK_W-1:0]    slBlockLen,
  output logic                           slBusy,
  // Detector block stream
  input  wire logic [31:0]               blkData,
  input  wire logic                      blkValid,
  output logic                           blkReady,
  // Primitive conditions
  input  wire logic [RFFMT_COND_W-1:0]   condMet,
  input  wire logic [RFFMT_FINE_W-1:0]   fineTime,
  // Frame output
  output logic [31:0]                    frmData,
  output logic                           frmValid,
  output logic                           frmLast,
  input  wire logic                      frmReady,
  // Primitive output
  output logic [31:0]                    primData,
  output logic                           primValid,
  output logic                           primLast,
  input  wire logic                      primReady,
  // Status lines
  output logic                           overloadLine,
  output logic                           errorLine
);

  // ****************************************************************
  // Shared counters
  // ****************************************************************
  logic [RFFMT_TS_W-1:0]  ts;
  logic [RFFMT_TS_W-1:0]  burstCount;
  logic [RFFMT_EVT_W-1:0] evtNum;
  logic                   inBurst;
  logic [31:0]            primDataW;
  logic                   primValidW;
  logic                   primLastW;
  logic                   primLate;
  logic                   primTake;

  rffmt_burst_counter uCnt (
    .clk         (clk),
    .rst_n       (rst_n),
    .burstStart  (burstStart),
    .burstEnd    (burstEnd),
    .hwTrigPulse (hwTrigPulse),
    .timestamp   (ts),
    .burstCount  (burstCount),
    .eventNumber (evtNum),
    .inBurst     (inBurst)
  );

  rffmt_primitive_encoder uPrim (
    .clk       (clk),
    .rst_n     (rst_n),
    .srcId     (srcId),
    .tsOffset  (tsOffset),
    .fineMask  (fineMask),
    .condMet   (condMet),
    .fineTime  (fineTime),
    .timestamp (ts),
    .primData  (primDataW),
    .primValid (primValidW),
    .primLast  (primLastW),
    .primReady (primTake),
    .primLate  (primLate)
  );

  // Single link out; the encoder steps only when this flop takes its word,
  // so a stalled sink never loses the second word
  assign primTake = !primValid || primReady;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primData  <= '0;
      primValid <= 1'b0;
      primLast  <= 1'b0;
    end else if (primTake) begin
      primData  <= primDataW;
      primValid <= primValidW;
      primLast  <= primLastW;
    end
  end

  // ****************************************************************
  // Request capture
  // ****************************************************************
  // Pending trigger-driven requests; only a second-level accept starts a frame without one
  logic                   countPend_r;
  logic                   statPend_r;
  logic                   trigPend_r;
  logic [7:0]             trigType_r;
  logic [RFFMT_TS_W-1:0]  trigTs_r;
  logic [RFFMT_EVT_W-1:0] trigEvt_r;
  logic                   lostTrig_r;
  logic                   startCount;
  logic                   startStat;
  logic                   startTrig;
  logic                   startSl;
  rffmt_state_t           state_r;

  function automatic logic isIdle(input rffmt_state_t s);
    return s == RFFMT_IDLE;
  endfunction

  assign startSl    = isIdle(state_r) && slAccept;
  assign startTrig  = isIdle(state_r) && !slAccept && trigPend_r;
  assign startCount = isIdle(state_r) && !slAccept && !trigPend_r && countPend_r;
  assign startStat  = isIdle(state_r) && !slAccept && !trigPend_r && !countPend_r && statPend_r;

  // Set wins over clear on every pending flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countPend_r <= 1'b0;
      statPend_r  <= 1'b0;
    end else begin
      countPend_r <= countReq || (countPend_r && !startCount);
      statPend_r  <= statusReq || (statPend_r && !startStat);
    end
  end

  // A hardware trigger is answered with a header-only frame unless a newer one overwrites it while pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigPend_r <= 1'b0;
      trigType_r <= '0;
      trigTs_r   <= '0;
      trigEvt_r  <= '0;
      lostTrig_r <= 1'b0;
    end else begin
      // Clear first so a loss in the same cycle still sets the flag
      if (burstStart) begin
        lostTrig_r <= 1'b0;
      end
      if (hwTrigPulse) begin
        trigPend_r <= 1'b1;
        trigType_r <= hwTrigType;
        trigTs_r   <= ts;
        trigEvt_r  <= evtNum;
        if (trigPend_r && !startTrig) begin
          lostTrig_r <= 1'b1;
        end
      end else if (startTrig) begin
        trigPend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  logic [31:0]            hdr_r [RFFMT_HDR_WORDS];
  logic [1:0]             hdrIdx_r;
  logic [RFFMT_BLK_W-1:0] blkLeft_r;
  logic [RFFMT_BLK_W-1:0] blkLen;
  logic                   tooBig_r;
  logic                   xfer;
  logic                   nxtValid;

  assign blkLen = (slBlockLen > RFFMT_MAX_BLK) ? RFFMT_MAX_BLK : slBlockLen;
  // Step when the output flop takes a word, not when it leaves, so none repeats
  assign xfer   = nxtValid && (!frmValid || frmReady);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= RFFMT_IDLE;
      hdrIdx_r  <= '0;
      blkLeft_r <= '0;
      for (int i = 0; i < RFFMT_HDR_WORDS; i++) begin
        hdr_r[i] <= '0;
      end
    end else begin
      unique case (state_r)
        RFFMT_IDLE: begin
          hdrIdx_r <= '0;
          if (startSl) begin
            hdr_r[0]  <= {8'h00, blkLen + 24'(RFFMT_HDR_WORDS)};
            hdr_r[1]  <= {srcId, slEventNum};
            hdr_r[2]  <= slTimestamp;
            hdr_r[3]  <= {8'h00, slTrigType};
            blkLeft_r <= blkLen;
            state_r   <= RFFMT_HDR;
          end else if (startTrig) begin
            hdr_r[0]  <= {8'h00, 24'(RFFMT_HDR_WORDS)};
            hdr_r[1]  <= {srcId, trigEvt_r};
            hdr_r[2]  <= trigTs_r;
            hdr_r[3]  <= {16'h0000, trigType_r};
            blkLeft_r <= '0;
            state_r   <= RFFMT_HDR;
          end else if (startCount) begin
            hdr_r[0]  <= {8'h00, RFFMT_CNT_WORDS + 24'(RFFMT_HDR_WORDS)};
            hdr_r[1]  <= {srcId, evtNum};
            hdr_r[2]  <= ts;
            hdr_r[3]  <= {24'h000000, RFFMT_TT_COUNT};
            blkLeft_r <= RFFMT_CNT_WORDS;
            state_r   <= RFFMT_HDR;
          end else if (startStat) begin
            hdr_r[0]  <= {8'h00, RFFMT_STAT_WORDS + 24'(RFFMT_HDR_WORDS)};
            hdr_r[1]  <= {srcId, evtNum};
            hdr_r[2]  <= ts;
            hdr_r[3]  <= {24'h000000, RFFMT_TT_STATUS};
            blkLeft_r <= RFFMT_STAT_WORDS;
            state_r   <= RFFMT_HDR;
          end
        end
        RFFMT_HDR: begin
          if (xfer) begin
            hdrIdx_r <= hdrIdx_r + 2'h1;
            if (hdrIdx_r == 2'h3) begin
              if (blkLeft_r == '0) begin
                state_r <= RFFMT_IDLE;
              end else if (hdr_r[3][7:0] == RFFMT_TT_COUNT) begin
                state_r <= RFFMT_CNT;
              end else if (hdr_r[3][7:0] == RFFMT_TT_STATUS) begin
                state_r <= RFFMT_STAT;
              end else begin
                state_r <= RFFMT_BLK;
              end
            end
          end
        end
        RFFMT_BLK, RFFMT_CNT, RFFMT_STAT, RFFMT_PAD: begin
          if (xfer) begin
            blkLeft_r <= blkLeft_r - 1'b1;
            if (blkLeft_r == 24'h000001) begin
              state_r <= RFFMT_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Output word mux, registered
  logic [31:0] nxtWord;
  logic [RFFMT_BLK_W-1:0] statIdx;

  assign statIdx = RFFMT_STAT_WORDS - blkLeft_r;

  always_comb begin
    nxtWord  = frmData;
    nxtValid = 1'b0;
    unique case (state_r)
      RFFMT_IDLE: begin
        nxtWord  = '0;
        nxtValid = 1'b0;
      end
      RFFMT_HDR: begin
        nxtWord  = hdr_r[hdrIdx_r];
        nxtValid = 1'b1;
      end
      RFFMT_BLK, RFFMT_PAD: begin
        nxtWord  = blkData;
        nxtValid = blkValid;
      end
      RFFMT_CNT: begin
        nxtWord  = burstCount;
        nxtValid = 1'b1;
      end
      RFFMT_STAT: begin
        unique case (statIdx[1:0])
          2'h0:    nxtWord = burstCount;
          2'h1:    nxtWord = {8'h00, evtNum};
          2'h2:    nxtWord = {29'h0, lostTrig_r, primLate, inBurst};
          default: nxtWord = {24'h000000, srcId};
        endcase
        nxtValid = 1'b1;
      end
    endcase
  end

  // Presented word mirrors state combinationally through one stage of flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frmData  <= '0;
      frmValid <= 1'b0;
      frmLast  <= 1'b0;
    end else if (!frmValid || frmReady) begin
      frmData  <= nxtWord;
      frmValid <= nxtValid;
      frmLast  <= nxtValid && ((state_r == RFFMT_HDR && hdrIdx_r == 2'h3 && blkLeft_r == '0)
                  || (state_r != RFFMT_HDR && blkLeft_r == 24'h000001));
    end
  end

  assign blkReady = 1'b0;
  assign slBusy   = 1'b0;

  // ****************************************************************
  // Status lines
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overloadLine <= 1'b0;
      errorLine    <= 1'b0;
      tooBig_r     <= 1'b0;
    end else begin
      overloadLine <= trigPend_r && hwTrigPulse;
      tooBig_r     <= startSl && (slBlockLen > RFFMT_MAX_BLK);
      errorLine    <= lostTrig_r || primLate || tooBig_r;
    end
  end

endmodule

// File: hdl/rffmt_primitive_encoder.sv
// Hardware-trigger primitive message builder with merge and watchdog.
// Assumes condition bits are already evaluated centrally, one link out.
module rffmt_primitive_encoder
  import rffmt_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Configuration
  input  wire logic [7:0]                srcId,
  input  wire logic [RFFMT_TS_W-1:0]     tsOffset,
  input  wire logic [RFFMT_FINE_W-1:0]   fineMask,
  // Conditions
  input  wire logic [RFFMT_COND_W-1:0]   condMet,
  input  wire logic [RFFMT_FINE_W-1:0]   fineTime,
  input  wire logic [RFFMT_TS_W-1:0]     timestamp,
  // Message stream
  output logic [31:0]                    primData,
  output logic                           primValid,
  output logic                           primLast,
  input  wire logic                      primReady,
  output logic                           primLate
);

  logic [RFFMT_COND_W-1:0] prevCond_r;
  logic [31:0]             word0_r;
  logic [31:0]             word1_r;
  logic                    pend_r;
  logic                    second_r;
  logic [31:0]             age_r;
  logic [RFFMT_COND_W-1:0] newCond;

  // New onsets only: a held condition reports its first time
  assign newCond = condMet & ~prevCond_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevCond_r <= '0;
    end else begin
      prevCond_r <= condMet;
    end
  end

  // One message slot; onsets during a send are dropped to keep latency bounded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word0_r  <= '0;
      word1_r  <= '0;
      pend_r   <= 1'b0;
      second_r <= 1'b0;
    end else if (!pend_r && |newCond) begin
      // Bitwise code keeps all newly met conditions visible
      word0_r  <= {srcId + RFFMT_PRIM_HW_OFS, 8'h00, newCond, fineTime & fineMask};
      word1_r  <= timestamp + tsOffset;
      pend_r   <= 1'b1;
      second_r <= 1'b0;
    end else if (pend_r && primReady) begin
      if (second_r) begin
        pend_r   <= 1'b0;
        second_r <= 1'b0;
      end else begin
        second_r <= 1'b1;
      end
    end
  end

  // Watchdog: age of the pending message against the latency budget
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_r    <= '0;
      primLate <= 1'b0;
    end else if (!pend_r) begin
      age_r    <= '0;
      primLate <= 1'b0;
    end else begin
      age_r <= age_r + 1'b1;
      if (age_r >= 32'(RFFMT_MAX_LAT_CYC / RFFMT_WDOG_DIV)) begin
        primLate <= 1'b1;
      end
    end
  end

  assign primData  = second_r ? word1_r : word0_r;
  assign primValid = pend_r;
  assign primLast  = second_r;

endmodule

// File: pkg/rffmt_pkg.sv
// Constants and types shared by the readout frame and primitive formatter.
// Assumes one 100 MHz clock domain and synchronous timing-link inputs.
package rffmt_pkg;

  // ****************************************************************
  // Identifiers
  // ****************************************************************
  localparam logic [7:0] RFFMT_TRIG_PROC_ID = 8'h40;
  localparam logic [7:0] RFFMT_PRIM_HW_OFS  = 8'h01;
  localparam logic [7:0] RFFMT_PRIM_SL_OFS  = 8'h02;
  // Arbitrary default for the own identifier
  localparam logic [7:0] RFFMT_DEF_SRC_ID   = 8'h3C;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int         RFFMT_HDR_WORDS  = 4;
  localparam int         RFFMT_LEN_W      = 24;
  localparam int         RFFMT_BLK_W      = 24;
  localparam int         RFFMT_SRC_MSB    = 31;
  localparam int         RFFMT_SRC_LSB    = 24;
  localparam int         RFFMT_EVT_W      = 24;
  localparam int         RFFMT_TS_W       = 32;
  localparam int         RFFMT_TS_CNT_W   = 31;
  localparam int         RFFMT_FINE_W     = 8;
  localparam int         RFFMT_COND_W     = 8;
  localparam int         RFFMT_TTYPE_W    = 24;
  // 60 MB in 32-bit words, less the 4 header words
  localparam logic [23:0] RFFMT_MAX_BLK   = 24'hEFFFFC;
  // Status frame: 4 words of status after the header
  localparam logic [23:0] RFFMT_STAT_WORDS = 24'h000004;
  localparam logic [23:0] RFFMT_CNT_WORDS  = 24'h000001;
  // Special frame trigger-type codes in the hardware byte
  localparam logic [7:0] RFFMT_TT_COUNT   = 8'hF1;
  localparam logic [7:0] RFFMT_TT_STATUS  = 8'hF2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int RFFMT_CLK_MHZ        = 100;
  localparam int RFFMT_MAX_LAT_US     = 100;
  localparam int RFFMT_MAX_LAT_CYC    = RFFMT_MAX_LAT_US * RFFMT_CLK_MHZ;
  // Watchdog fires with margin at half the latency
  localparam int RFFMT_WDOG_DIV       = 2;

  typedef enum logic [5:0] {
    RFFMT_IDLE = 6'h01,
    RFFMT_HDR  = 6'h02,
    RFFMT_BLK  = 6'h04,
    RFFMT_CNT  = 6'h08,
    RFFMT_STAT = 6'h10,
    RFFMT_PAD  = 6'h20
  } rffmt_state_t;

  typedef enum logic [1:0] {
    RFFMT_K_EVENT = 2'h0,
    RFFMT_K_COUNT = 2'h1,
    RFFMT_K_STAT  = 2'h2
  } rffmt_kind_t;

endpackage

// File: test/rffmt_formatter_bench.sv
// Self-checking bench for the formatter top.
// Assumes the sink model paces both streams; block stream left idle.
module rffmt_formatter_bench import rffmt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic sl; logic [7:0] src; logic [23:0] tt; logic [23:0] evt;} rffmt_row_t;
  rffmt_row_t  rows[4] = '{'{0, 8'h3C, 24'h11, 0}, '{0, 8'h7A, 24'hA5, 0},
                          '{1, 8'h3C, 24'h030201, 24'h00ABCD}, '{1, 8'hFF, 24'hFFFFFF, 24'hFFFFFF}};
  logic        clk, rst_n, burstStart, burstEnd, hwTrigPulse, countReq, statusReq, slAccept, seen;
  logic        blkValid, frmValid, frmLast, frmReady, primValid, primLast, primReady, overloadLine, errorLine, slow;
  logic [7:0]  srcId, fineMask, hwTrigType, condMet, fineTime;
  logic [31:0] tsOffset, slTimestamp, blkData, frmData, primData, e;
  logic [23:0] slTrigType, slEventNum, slBlockLen;
  logic [31:0] fw[8];
  int          fn, numErrors, cmpCount;

  // One timing link feeds this single source; grouped sources would share it
  rffmt_formatter u_rffmt_formatter (.slBusy(), .blkReady(), .*);
  rffmt_sink_model u_sink (.*);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask

  task automatic cmp32(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmpCount++;
    if (g !== x) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Collects one frame or primitive message; bounded so a hang ends the run
  task automatic grab(input bit p);
    logic d;
    d = 0;
    fn = 0;
    for (int t = 0; t < 400 && !d; t++) begin
      @(negedge clk);
      if (p ? (primValid && primReady) : (frmValid && frmReady)) begin
        fw[fn[2:0]] = p ? primData : frmData;
        fn++;
        d = p ? primLast : frmLast;
      end
    end
    tick(1);
    if (!d) begin
      numErrors++;
      $display("CHECK FAILED stream timeout");
      printVerdict();
    end
  endtask

  initial begin
    {rst_n, burstStart, burstEnd, hwTrigPulse, countReq, statusReq, slAccept, blkValid, slow} = '0;
    {srcId, fineMask, hwTrigType, condMet, fineTime, tsOffset, slTimestamp, blkData} = '0;
    {slTrigType, slEventNum, slBlockLen} = '0;
    tick(16);
    rst_n = 1;
    tick(2);
    foreach (rows[i]) begin
      srcId = rows[i].src;
      slow = i[0];
      if (rows[i].sl) begin
        slTrigType = rows[i].tt;
        slEventNum = rows[i].evt;
        slTimestamp = {8'h12, rows[i].evt};
        pulse(slAccept);
      end else begin
        hwTrigType = rows[i].tt[7:0];
        pulse(hwTrigPulse);
      end
      grab(0);
      cmp32("length", 32'h4, fw[0]);
      cmp32("words", 32'h4, fn);
      cmp32("source", {24'h0, rows[i].src}, {24'h0, fw[1][31:24]});
      cmp32("ttype", {24'h0, rows[i].tt[7:0]}, {24'h0, fw[3][7:0]});
      if (rows[i].sl) cmp32("type word", {8'h0, rows[i].tt}, fw[3]);
      if (rows[i].sl) cmp32("event", {8'h0, rows[i].evt}, {8'h0, fw[1][23:0]});
      if (rows[i].sl) cmp32("stamp", slTimestamp, fw[2]);
      $display("test row %0d done", i);
    end
    pulse(burstStart);
    tick(48);
    pulse(burstEnd);
    pulse(countReq);
    grab(0);
    cmp32("count len", 32'h5, fw[0]);
    cmp32("count type", {24'h0, RFFMT_TT_COUNT}, {24'h0, fw[3][7:0]});
    cmp32("count span", 32'h1, {31'h0, fw[4] >= 32'd48 && fw[4] <= 32'd51});
    pulse(statusReq);
    grab(0);
    cmp32("status len", 32'h8, fw[0]);
    cmp32("status type", {24'h0, RFFMT_TT_STATUS}, {24'h0, fw[3][7:0]});
    cmp32("status src", {24'h0, srcId}, fw[7]);
    $display("test count and status done");
    pulse(hwTrigPulse);
    grab(0);
    e = fw[1];
    pulse(hwTrigPulse);
    grab(0);
    cmp32("event step", {8'h0, e[23:0] + 24'h1}, {8'h0, fw[1][23:0]});
    $display("test event step done");
    // Two conditions at once; source id 0xFF wraps on the primitive offset
    fineMask = 8'hF0;
    fineTime = 8'h5A;
    tsOffset = 32'h10;
    condMet = 8'h05;
    grab(1);
    cmp32("prim head", {srcId + RFFMT_PRIM_HW_OFS, 8'h00, 8'h05, 8'h50}, fw[0]);
    cmp32("prim words", 32'h2, fn);
    cmp32("prim msb", 32'h0, {31'h0, fw[1][31]});
    seen = 0;
    repeat (30) begin
      tick(1);
      seen |= primValid;
    end
    cmp32("held cond", 32'h0, {31'h0, seen});
    condMet = 8'h00;
    $display("test primitive done");
    // Three back-to-back triggers: the second is overwritten while the first is sent
    hwTrigPulse = 1;
    tick(3);
    hwTrigPulse = 0;
    cmp32("overload line", 32'h1, {31'h0, overloadLine});
    tick(1);
    cmp32("error line", 32'h1, {31'h0, errorLine});
    grab(0);
    grab(0);
    $display("test double trigger done");
    rst_n = 0;
    tick(2);
    cmp32("reset outs", 32'h0, {28'h0, frmValid, primValid, errorLine, overloadLine});
    rst_n = 1;
    seen = 0;
    repeat (30) begin
      tick(1);
      seen |= frmValid;
    end
    cmp32("unsolicited", 32'h0, {31'h0, seen});
    $display("test reset done");
    printVerdict();
  end

  initial begin
    #900000;
    numErrors++;
    $display("CHECK FAILED run timeout");
    printVerdict();
  end
endmodule

// File: test/rffmt_formatter_checker.sv
// Port checker for the formatter top.
// Assumes binding onto rffmt_formatter, one clock domain.
module rffmt_formatter_checker
  import rffmt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Inputs watched
  input  wire logic [7:0]  srcId,
  input  wire logic [7:0]  fineMask,
  input  wire logic        hwTrigPulse,
  input  wire logic        countReq,
  input  wire logic        statusReq,
  input  wire logic        slAccept,
  input  wire logic        frmReady,
  input  wire logic        primReady,
  // Outputs watched
  input  wire logic [31:0] frmData,
  input  wire logic        frmValid,
  input  wire logic        frmLast,
  input  wire logic [31:0] primData,
  input  wire logic        primValid,
  input  wire logic        primLast,
  input  wire logic        errorLine,
  input  wire logic        overloadLine
);
  // ****
  // Helper state: word position and length of the frame in flight
  // ****
  logic [23:0] wordIdx_r;
  logic [23:0] lenR_r;
  logic        reqSeen_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wordIdx_r <= 24'h0;
    else if (frmValid && frmReady) wordIdx_r <= frmLast ? 24'h0 : wordIdx_r + 24'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lenR_r <= 24'h0;
    else if (frmValid && frmReady && wordIdx_r == 24'h0) lenR_r <= frmData[23:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reqSeen_r <= 1'b0;
    else if (hwTrigPulse || countReq || statusReq || slAccept) reqSeen_r <= 1'b1;
  end

  frm_hold_a: assert property (frmValid && !frmReady |=> frmValid && $stable(frmData) && $stable(frmLast))
    else $error("frame word changed while stalled");
  prim_hold_a: assert property (primValid && !primReady |=> primValid && $stable(primData))
    else $error("primitive word changed while stalled");
  frame_len_a: assert property (frmValid && frmLast |-> wordIdx_r == lenR_r - 24'h1)
    else $error("last word disagrees with word count");
  frame_src_a: assert property (frmValid && wordIdx_r == 24'h1 |-> frmData[31:24] == srcId)
    else $error("frame source id wrong");
  prim_head_a: assert property (primValid && !primLast |-> primData[31:16] == {srcId + 8'h01, 8'h00})
    else $error("primitive head wrong");
  fine_mask_a: assert property (primValid && !primLast |-> (primData[7:0] & ~fineMask) == 8'h00)
    else $error("fine time not masked");
  no_unsol_a: assert property (frmValid |-> reqSeen_r)
    else $error("frame sent without request");
  trig_answer_a: assert property (hwTrigPulse |-> ##[1:60] frmValid)
    else $error("trigger not answered");
  double_trig_a: assert property (hwTrigPulse ##1 hwTrigPulse |=> overloadLine)
    else $error("back-to-back trigger not flagged as overload");
  lost_trig_a: assert property (hwTrigPulse ##1 hwTrigPulse ##1 hwTrigPulse |=> ##1 errorLine)
    else $error("lost trigger not flagged as error");
  reset_quiet_a: assert property ($rose(rst_n) |-> !frmValid && !primValid)
    else $error("output active at reset release");
endmodule

bind rffmt_formatter rffmt_formatter_checker u_rffmt_formatter_checker (.*);

// File: test/rffmt_sink_model.sv
// Far-side sink model for the frame and primitive streams.
// Assumes valid/ready streams; in slow mode it takes one word in three.
module rffmt_sink_model
  import rffmt_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pace select
  input  wire logic slow,
  // Ready outputs
  output logic      frmReady,
  output logic      primReady
);
  logic [1:0] pace_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pace_r <= 2'h0;
    else pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
  end

  // In slow mode stalls are offset so the two streams never free up together
  // Primitives are taken within one pace period, so none reach us late
  assign frmReady  = !slow || pace_r == 2'h0;
  assign primReady = !slow || pace_r == 2'h1;
endmodule
